// [shared/tpf_pkg.sv]
// Constants and carrier types for the transmit parallel character front end
package tpf_pkg;

  // ****************************************************************
  // Register map (APB byte addresses) and field positions
  // ****************************************************************
  localparam logic [7:0] TPF_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TPF_ADDR_STATUS = 8'h04;
  localparam int TPF_CTRL_QUEUE_BIT = 0;
  localparam int TPF_CTRL_CODER_BIT = 1;
  localparam int TPF_CTRL_WIDTH_BIT = 2;
  localparam logic [2:0] TPF_CTRL_RESET = 3'h7;
  localparam int TPF_ST_COUNT_LSB = 0;
  localparam int TPF_ST_EMPTY_BIT = 9;
  localparam int TPF_ST_FULL_BIT = 10;
  localparam int TPF_ST_PAUSED_BIT = 11;
  localparam int TPF_ST_FLAG_BIT = 12;
  localparam int TPF_ST_PEND_BIT = 13;

  // ****************************************************************
  // Queue geometry and character timing
  // ****************************************************************
  localparam int TPF_QDEPTH = 256;
  localparam int TPF_QAW = 8;
  localparam logic [8:0] TPF_QFULL = 9'h100;
  localparam logic [3:0] TPF_BITS_SHORT = 4'hA;
  localparam logic [3:0] TPF_BITS_LONG = 4'hC;

  // ****************************************************************
  // Special characters, byte = y*32 + x for code Cx.y
  // ****************************************************************
  localparam logic [7:0] TPF_CODE_FLAG_RISE = 8'h00;
  localparam logic [7:0] TPF_CODE_FLAG_FALL = 8'h03;
  localparam logic [7:0] TPF_CODE_IDLE = 8'h05;
  localparam logic [7:0] TPF_CODE_VIOL = 8'hE0;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic write;
    logic ctrl_sel;
    logic [11:0] word;
  } tpf_pin_t;

  typedef struct packed {
    logic ctrl_sel;
    logic [11:0] word;
  } tpf_qent_t;

  typedef struct packed {
    logic k;
    logic viol;
    logic soc;
    logic raw;
    logic [11:0] data;
  } tpf_sym_t;

endpackage

// [src/tpf_front_end.sv]
// Transmit parallel character front end: input stage, queue, selector, serializer
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
// How it works
// - Host characters are 8, 10 or 12 bits wide
// - Bypass: low byte is raw char low bits
// - Flag toggle meaningful only with queue+encoder
// - Flag change inserts special ahead of queue
// - Rise sends C0.0, fall sends C3.0
// - Queue bypass: ignore flag, pause, cell start
// - Full bypass: bit 8 is ninth bit
// - Pause stops reads, sends idle, writes continue
// - Encoder bypass: bit 9 is tenth bit
// - Violation, cell start, control select decide type
// - Queue bypass violation sends C0.7 instead
// - Raw 12-bit mode: bit 10 eleventh bit
// - Raw 10-bit mode ignores bits 10, 11
// - Cell start carried as frame delimiter
// - Raw 12-bit mode: bit 11 is MSB
// - Queue holds 256, bypassable
// - Inputs sampled on the one block clock
// - Queue bypass: control select picks data/control
// - Encoder bypass ignores control select
module tpf_front_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] tx_word,
  input wire logic tx_ctrl_sel,
  input wire logic tx_write,
  output logic tx_full,
  output tpf_pkg::tpf_sym_t sym_out,
  output logic sym_valid,
  output logic serial_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tpf_pkg::tpf_pin_t pin_s1_reg;
  tpf_pkg::tpf_pin_t pin_s2_reg;
  logic [2:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  tpf_pkg::tpf_qent_t qmem [tpf_pkg::TPF_QDEPTH];
  logic [7:0] wr_ptr_reg;
  logic [7:0] rd_ptr_reg;
  logic [8:0] count_reg;
  logic [8:0] count_next;
  logic full_reg;
  logic flag_last_reg;
  logic flag_pend_reg;
  logic flag_rise_reg;
  logic [3:0] bit_cnt_reg;
  logic [11:0] shift_reg;
  logic serial_reg;
  tpf_pkg::tpf_sym_t sym_reg;
  logic sym_valid_reg;
  logic queue_on;
  logic coder_on;
  logic width8;
  logic qe_mode;
  logic flag_edge;
  logic paused;
  logic slot;
  logic q_wr;
  logic q_rd;
  logic q_empty;
  logic take_flag;
  logic [3:0] bits_per;
  tpf_pkg::tpf_qent_t q_head;
  tpf_pkg::tpf_qent_t src;
  tpf_pkg::tpf_sym_t sym_next;
  logic [11:0] payload;
  logic apb_wr;

  // ****************************************************************
  // Pin synchroniser and mode decode
  // ****************************************************************

  // Two stages before any use; stage one feeds stage two only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end
    else
    begin
      pin_s1_reg <= '{write: tx_write, ctrl_sel: tx_ctrl_sel, word: tx_word};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Mode bits come from the control register
  assign queue_on = ctrl_reg[tpf_pkg::TPF_CTRL_QUEUE_BIT];
  assign coder_on = ctrl_reg[tpf_pkg::TPF_CTRL_CODER_BIT];
  assign width8 = ctrl_reg[tpf_pkg::TPF_CTRL_WIDTH_BIT];
  assign qe_mode = queue_on && coder_on;

  // ****************************************************************
  // APB slave
  // ****************************************************************

  // Zero wait states: answer is ready in the first access cycle
  assign apb_wr = psel && penable && pready_reg && pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end
    else
    begin
      pready_reg <= psel && !penable;
      pslverr_reg <= psel && !penable && (paddr != tpf_pkg::TPF_ADDR_CTRL) && (paddr != tpf_pkg::TPF_ADDR_STATUS);
      prdata_reg <= '0;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == tpf_pkg::TPF_ADDR_CTRL)
        begin
          prdata_reg <= {29'h0000000, ctrl_reg};
        end
        else if (paddr == tpf_pkg::TPF_ADDR_STATUS)
        begin
          prdata_reg[tpf_pkg::TPF_ST_COUNT_LSB +: 9] <= count_reg;
          prdata_reg[tpf_pkg::TPF_ST_EMPTY_BIT] <= q_empty;
          prdata_reg[tpf_pkg::TPF_ST_FULL_BIT] <= full_reg;
          prdata_reg[tpf_pkg::TPF_ST_PAUSED_BIT] <= paused;
          prdata_reg[tpf_pkg::TPF_ST_FLAG_BIT] <= flag_last_reg;
          prdata_reg[tpf_pkg::TPF_ST_PEND_BIT] <= flag_pend_reg;
        end
      end
    end
  end

  // Control register; status is read only, unmapped writes dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= tpf_pkg::TPF_CTRL_RESET;
    end
    else if (apb_wr && paddr == tpf_pkg::TPF_ADDR_CTRL)
    begin
      ctrl_reg <= pwdata[2:0];
    end
  end

  // ****************************************************************
  // Transmit queue
  // ****************************************************************

  assign q_empty = (count_reg == 9'h000);
  assign q_wr = queue_on && pin_s2_reg.write && !full_reg;
  assign q_head = qmem[rd_ptr_reg];

  // Occupancy; a simultaneous read and write leaves it unchanged
  always_comb
  begin
    count_next = count_reg;
    if (q_wr && !q_rd)
    begin
      count_next = count_reg + 9'h001;
    end
    else if (q_rd && !q_wr)
    begin
      count_next = count_reg - 9'h001;
    end
  end

  // Storage has no reset; only pointers define what is valid
  always_ff @(posedge pclk)
  begin
    if (q_wr)
    begin
      qmem[wr_ptr_reg] <= '{ctrl_sel: pin_s2_reg.ctrl_sel, word: pin_s2_reg.word};
    end
  end

  // Bypassing the queue flushes it so stale words never leak out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
    end
    else if (!queue_on)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
    end
    else
    begin
      if (q_wr)
      begin
        wr_ptr_reg <= wr_ptr_reg + 8'h01;
      end
      if (q_rd)
      begin
        rd_ptr_reg <= rd_ptr_reg + 8'h01;
      end
      count_reg <= count_next;
      full_reg <= (count_next == tpf_pkg::TPF_QFULL);
    end
  end

  // ****************************************************************
  // Flag toggle tracking
  // ****************************************************************

  // Level follows bit 8 always, so entering the mode raises no event
  assign flag_edge = qe_mode && (pin_s2_reg.word[8] != flag_last_reg);
  assign paused = qe_mode && !pin_s2_reg.word[9];

  // Pending insert; a new edge wins over the clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_last_reg <= 1'b0;
      flag_pend_reg <= 1'b0;
      flag_rise_reg <= 1'b0;
    end
    else
    begin
      flag_last_reg <= pin_s2_reg.word[8];
      if (flag_edge)
      begin
        flag_pend_reg <= 1'b1;
        flag_rise_reg <= pin_s2_reg.word[8];
      end
      else if (take_flag || !qe_mode)
      begin
        flag_pend_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Character selection
  // ****************************************************************

  assign slot = (bit_cnt_reg == 4'h0);
  assign take_flag = slot && flag_pend_reg && qe_mode;
  // Flag insert goes around the queue and stalls its read for one slot
  assign q_rd = queue_on && slot && !q_empty && !flag_pend_reg && !paused;
  assign bits_per = (!coder_on && !width8) ? tpf_pkg::TPF_BITS_LONG : tpf_pkg::TPF_BITS_SHORT;

  // Source word: queue head when queued, pin word when bypassed
  assign src = queue_on ? q_head : tpf_pkg::tpf_qent_t'{ctrl_sel: pin_s2_reg.ctrl_sel, word: pin_s2_reg.word};

  // Priority: flag insert, pause, then data; idle when nothing to send
  always_comb
  begin
    sym_next = '{k: 1'b1, viol: 1'b0, soc: 1'b0, raw: 1'b0, data: {4'h0, tpf_pkg::TPF_CODE_IDLE}};
    if (take_flag)
    begin
      sym_next.data = {4'h0, flag_rise_reg ? tpf_pkg::TPF_CODE_FLAG_RISE : tpf_pkg::TPF_CODE_FLAG_FALL};
    end
    else if (queue_on ? q_rd : pin_s2_reg.write)
    begin
      if (!coder_on)
      begin
        // Raw path: control select is not looked at
        sym_next.k = 1'b0;
        sym_next.raw = 1'b1;
        sym_next.data[9:0] = src.word[9:0];
        sym_next.data[11:10] = width8 ? 2'h0 : src.word[11:10];
      end
      else if (!queue_on)
      begin
        // Bypassed queue: bits 8, 9 and 11 are not interpreted
        sym_next.k = src.ctrl_sel;
        sym_next.data = {4'h0, src.word[7:0]};
        if (src.word[10])
        begin
          sym_next.viol = 1'b1;
          sym_next.data = {4'h0, tpf_pkg::TPF_CODE_VIOL};
        end
      end
      else
      begin
        // Queue and encoder on: three bits pick the character type
        sym_next.k = src.ctrl_sel;
        sym_next.soc = src.word[11];
        sym_next.data = {4'h0, src.word[7:0]};
        if (src.word[10])
        begin
          sym_next.viol = 1'b1;
          sym_next.data = {4'h0, tpf_pkg::TPF_CODE_VIOL};
        end
      end
    end
  end

  // Serial payload: raw bits, or k/violation flags above the byte
  assign payload = sym_next.raw ? sym_next.data : {2'h0, sym_next.viol, sym_next.k, sym_next.data[7:0]};

  // ****************************************************************
  // Character slot timer and serializer
  // ****************************************************************

  // One bit per clock; a new character every ten or twelve clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= '0;
      serial_reg <= 1'b0;
      sym_reg <= '0;
      sym_valid_reg <= 1'b0;
    end
    else if (slot)
    begin
      bit_cnt_reg <= bits_per - 4'h1;
      serial_reg <= payload[0];
      shift_reg <= {1'b0, payload[11:1]};
      sym_reg <= sym_next;
      sym_valid_reg <= 1'b1;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg - 4'h1;
      serial_reg <= shift_reg[0];
      shift_reg <= {1'b0, shift_reg[11:1]};
      sym_valid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_full = full_reg; // Queue full flop doubles as host back-pressure
  assign sym_out = sym_reg;
  assign sym_valid = sym_valid_reg;
  assign serial_out = serial_reg;

endmodule

// [verification/tpf_host_model.sv]
// Host-side model that presents parallel transmit characters
`timescale 1ns/1ps
module tpf_host_model (
  input logic pclk,
  input logic presetn,
  input logic [11:0] req_word,
  input logic req_ctrl,
  input logic req_write,
  output tpf_pkg::tpf_pin_t pin
);
  // Launch right after the clock edge so the device samples a settled word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin <= {2'b00, 12'h200}; // Pause released, as a pulled-up pin would be
    else
    begin
      pin.word <= req_word;
      pin.ctrl_sel <= req_ctrl;
      pin.write <= req_write;
    end
  end
endmodule

// [verification/tpf_front_end_properties.sv]
// Port checker for the transmit front end
`timescale 1ns/1ps
module tpf_front_end_chk (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic tx_full,
  input tpf_pkg::tpf_sym_t sym_out,
  input logic sym_valid,
  input logic serial_out
);
  logic [3:0] calm_reg;

  // Quiet cycles since a register write; a mode change may alter the length of later slots
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      calm_reg <= 4'h0;
    else if (psel && pwrite)
      calm_reg <= 4'h0;
    else if (calm_reg != 4'hF)
      calm_reg <= calm_reg + 4'h1;
  end

  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // Slot timing and serial order
  // ****************************************************************
  a_slot_gap: assert property (disable iff (!presetn || (psel && pwrite))
    sym_valid && calm_reg == 4'hF |=> !sym_valid [*8]) else $error("slot strobe too soon");
  a_slot_ten: assert property (disable iff (!presetn || (psel && pwrite))
    sym_valid && !sym_out.raw && !(sym_out.k && sym_out.data[7:0] == tpf_pkg::TPF_CODE_IDLE)
    && calm_reg == 4'hF |-> ##10 sym_valid) else $error("encoded slot not ten");
  a_slot_twelve: assert property (disable iff (!presetn || (psel && pwrite))
    sym_valid && sym_out.raw && sym_out.data[11:10] != 2'h0 && calm_reg == 4'hF |-> ##12 sym_valid)
    else $error("wide raw slot not twelve");
  a_serial_lsb: assert property (sym_valid |-> serial_out == sym_out.data[0])
    else $error("serial not LSB first");
  a_serial_tail: assert property (disable iff (!presetn || (psel && pwrite))
    sym_valid && !sym_out.raw |-> ##8 serial_out == sym_out.k ##1 serial_out == sym_out.viol)
    else $error("serial tail wrong");
  a_sym_hold: assert property (!sym_valid |-> $stable(sym_out))
    else $error("symbol changed mid slot");
  a_viol_code: assert property (sym_valid && sym_out.viol |-> sym_out.data[7:0] == tpf_pkg::TPF_CODE_VIOL)
    else $error("violation code wrong");
  a_raw_plain: assert property (sym_valid && sym_out.raw |-> !sym_out.k && !sym_out.viol)
    else $error("raw char marked");

  // ****************************************************************
  // Register bus answers
  // ****************************************************************
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one access cycle");
  a_apb_err: assert property (pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04))
    else $error("pslverr wrong");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("error read not zero");

  // Main scenarios reached
  c_viol: cover property (sym_valid && sym_out.viol);
  c_full: cover property (tx_full);
  c_raw: cover property (sym_valid && sym_out.raw);
endmodule

bind tpf_front_end tpf_front_end_chk u_tpf_front_end_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .tx_full, .sym_out, .sym_valid, .serial_out);

// [verification/tb_top.sv]
// Self-checking testbench for the transmit front end
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] req_word;
  logic req_ctrl, req_write, e, tx_full, sym_valid, serial_out;
  tpf_pkg::tpf_pin_t pin;
  tpf_pkg::tpf_sym_t sym_out;
  int fails, check_count;
  localparam logic [2:0] T_CTRL [11] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h6, 3'h0, 3'h4, 3'h5};
  localparam logic [11:0] T_WORD [11] = '{12'h241, 12'h2BC, 12'h640, 12'hA22, 12'h300, 12'h200,
    12'h9BC, 12'h4BC, 12'hABC, 12'hEBC, 12'h3C5};
  localparam logic T_SEL [11] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  localparam logic T_WR [11] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam logic [15:0] T_EXP [11] = '{16'h0041, 16'h80BC, 16'h40E0, 16'h2022, 16'h8000, 16'h8003,
    16'h80BC, 16'h40E0, 16'h1ABC, 16'h12BC, 16'h13C5};

  tpf_host_model u_tpf_host_model (.pclk(pclk), .presetn(presetn), .req_word(req_word),
    .req_ctrl(req_ctrl), .req_write(req_write), .pin(pin));
  tpf_front_end u_tpf_front_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_word(pin.word), .tx_ctrl_sel(pin.ctrl_sel), .tx_write(pin.write), .tx_full(tx_full),
    .sym_out(sym_out), .sym_valid(sym_valid), .serial_out(serial_out));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One APB transfer; request holds until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic host(input logic [11:0] w, input logic c, input logic wr);
    @(posedge pclk);
    req_word <= w;
    req_ctrl <= c;
    req_write <= wr;
  endtask

  // Skip idle slots; wait bounded for the next real character
  task automatic next_sym(input logic [15:0] exp);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (!(sym_valid === 1'b1 && sym_out !== 16'h8005) && n < 400);
    if (!(sym_valid === 1'b1 && sym_out !== 16'h8005))
      fails++;
    chk("sym_out", sym_out, {16'h0, exp});
  endtask

  // Free-running bus clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Hang guard, well beyond the longest expected run
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {presetn, psel, penable, pwrite, req_ctrl, req_write} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_word = 12'h200;
    fails = 0;
    check_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h7);
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", q, 32'h200);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    // Pause, then fill the queue past its depth; writes still land while paused
    host(12'h000, 1'b0, 1'b0);
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 260; i++)
      host({4'h0, i[7:0]}, 1'b0, 1'b1);
    host(12'h000, 1'b0, 1'b0);
    repeat (4) @(posedge pclk);
    chk("tx_full", {31'h0, tx_full}, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("status_full", q, 32'hD00);
    host(12'h200, 1'b0, 1'b0);
    next_sym(16'h0000);
    repeat (2600) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk("status_drained", q, 32'h200);
    // Character kinds over every mode: queue, bypass, raw 12 and raw 10
    for (int i = 0; i < 11; i++)
    begin
      host(12'h200 | (req_word & 12'h100), 1'b0, 1'b0);
      apb(1'b1, 8'h00, {29'h0, T_CTRL[i]});
      host(T_WORD[i], T_SEL[i], T_WR[i]);
      if (T_CTRL[i][0])
        host(12'h200 | (T_WORD[i] & 12'h100), 1'b0, 1'b0);
      else
        repeat (16) @(posedge pclk);
      next_sym(T_EXP[i]);
    end
    close_out();
  end
endmodule
